// File: hw/mpgm_gpio_top.sv
// Port-two pull-ups, port-three and port-four GPIO with Avalon-MM registers.
// Assumes mode, standby and port-two direction come from chip control logic.
`timescale 1ns/1ps
module mpgm_gpio_top (
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic [2:0]  i_mode,
  input  wire logic        i_hw_standby,
  input  wire logic        i_sw_standby,
  input  wire logic [7:0]  i_port2_direction,
  input  wire logic [13:0] i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  input  wire logic [7:0]  i_p3_pin,
  input  wire logic [7:0]  i_p4_pin,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic      [7:0]  o_p2_pullup_en,
  output logic      [7:0]  o_p3_out,
  output logic      [7:0]  o_p3_oe,
  output logic      [7:0]  o_p4_out,
  output logic      [7:0]  o_p4_oe,
  output logic      [7:0]  o_p4_pullup_en,
  output logic             o_p3_is_bus,
  output logic             o_p4_is_bus
);
  import mpgm_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  port2_pullup_control;
    logic [7:0]  port3_direction;
    logic [7:0]  port3_output_data;
    logic [7:0]  port4_direction;
    logic [7:0]  port4_output_data;
    logic [7:0]  port4_pullup_control;
    logic [7:0]  area_bus_width_config;
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  p2_pu;
    logic [7:0]  p3_out;
    logic [7:0]  p3_oe;
    logic [7:0]  p4_out;
    logic [7:0]  p4_oe;
    logic [7:0]  p4_pu;
    logic        p3_bus;
    logic        p4_bus;
  } mpgm_state_s;

  mpgm_state_s st_r;
  mpgm_state_s st_nxt;
  mpgm_sync_if sif ();
  logic [15:0] hold_q;

  assign sif.p3_raw = i_p3_pin;
  assign sif.p4_raw = i_p4_pin;

  mpgm_pin_sync u_sync (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .s          (sif.sync)
  );

  mpgm_sw_standby_latch #(.W(16)) u_hold (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_hold     (i_sw_standby),
    .i_d        ({st_r.port4_output_data, st_r.port3_output_data}),
    .o_q        (hold_q)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] mpgm_mix(input logic [7:0] dir, input logic [7:0] dat,
                                          input logic [7:0] pin);
    mpgm_mix = (dir & dat) | (~dir & pin);
  endfunction

  function automatic logic [7:0] mpgm_wr(input logic [7:0] old, input logic [31:0] wd,
                                         input logic be);
    mpgm_wr = be ? wd[7:0] : old;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic [15:0] idx;
  logic        req;
  logic        single;
  logic        rom_on;
  logic        p3_gpio;
  logic        p4_gpio;
  logic        any16;

  always_comb begin
    st_nxt  = st_r;
    idx     = {2'h3, i_avs_address};
    req     = (i_avs_read || i_avs_write) && !st_r.ack;
    single  = (i_mode == MODE_SINGLE);
    rom_on  = (i_mode >= MODE_ROM_ON);
    any16   = |st_r.area_bus_width_config;                     // R15
    p3_gpio = single;                                          // R6
    p4_gpio = single || !any16;                                // R14 R16
    st_nxt.ack = req;
    if (req && i_avs_write) begin
      if (idx == P3_DIR_IDX) begin
        st_nxt.port3_direction = mpgm_wr(st_r.port3_direction, i_avs_writedata,
                                         i_avs_byteenable[0]);
      end else if (idx == P4_DIR_IDX) begin
        st_nxt.port4_direction = mpgm_wr(st_r.port4_direction, i_avs_writedata,
                                         i_avs_byteenable[0]);
      end else if (idx == P3_DATA_IDX) begin
        st_nxt.port3_output_data = mpgm_wr(st_r.port3_output_data, i_avs_writedata,
                                           i_avs_byteenable[0]);
      end else if (idx == P4_DATA_IDX) begin
        st_nxt.port4_output_data = mpgm_wr(st_r.port4_output_data, i_avs_writedata,
                                           i_avs_byteenable[0]);
      end else if (idx == P2_PULL_IDX) begin
        st_nxt.port2_pullup_control = mpgm_wr(st_r.port2_pullup_control,  // R4
                                              i_avs_writedata, i_avs_byteenable[0]);
      end else if (idx == P4_PULL_IDX) begin
        st_nxt.port4_pullup_control = mpgm_wr(st_r.port4_pullup_control,
                                              i_avs_writedata, i_avs_byteenable[0]);
      end else if (idx == BUS_WIDTH_IDX) begin
        st_nxt.area_bus_width_config = mpgm_wr(st_r.area_bus_width_config,
                                               i_avs_writedata, i_avs_byteenable[0]);
      end
    end
    if (req && i_avs_read) begin
      if (idx == P3_DIR_IDX || idx == P4_DIR_IDX) begin
        st_nxt.rdata = {24'h000000, WO_READ_VAL};             // R8 R18
      end else if (idx == P3_DATA_IDX) begin
        st_nxt.rdata = {24'h000000, mpgm_mix(st_r.port3_direction,  // R12
                        st_r.port3_output_data, sif.p3_sync)};      // R20
      end else if (idx == P4_DATA_IDX) begin
        st_nxt.rdata = {24'h000000, mpgm_mix(st_r.port4_direction,
                        st_r.port4_output_data, sif.p4_sync)};
      end else if (idx == P2_PULL_IDX) begin
        st_nxt.rdata = {24'h000000, st_r.port2_pullup_control};
      end else if (idx == P4_PULL_IDX) begin
        st_nxt.rdata = {24'h000000, st_r.port4_pullup_control};
      end else if (idx == BUS_WIDTH_IDX) begin
        st_nxt.rdata = {24'h000000, st_r.area_bus_width_config};
      end else begin
        st_nxt.rdata = UNMAPPED_VAL;
      end
    end
    // Pin drive
    st_nxt.p3_bus = !p3_gpio;                                  // R6
    st_nxt.p4_bus = !p4_gpio;                                  // R15
    st_nxt.p3_oe  = p3_gpio ? st_r.port3_direction : 8'h00;   // R7
    st_nxt.p4_oe  = p4_gpio ? st_r.port4_direction : 8'h00;   // R17
    st_nxt.p3_out = i_sw_standby ? hold_q[7:0] : st_r.port3_output_data;   // R11 R10
    st_nxt.p4_out = i_sw_standby ? hold_q[15:8] : st_r.port4_output_data;
    st_nxt.p2_pu  = rom_on ? (~i_port2_direction & st_r.port2_pullup_control)
                           : 8'h00;                            // R1 R2
    st_nxt.p4_pu  = p4_gpio ? (~st_r.port4_direction & st_r.port4_pullup_control)
                            : 8'h00;                           // R19
    if (i_hw_standby) begin
      st_nxt = '0;                                             // R3 R5 R9 R13
      st_nxt.port2_pullup_control  = REG_RESET;
      st_nxt.port3_direction       = REG_RESET;
      st_nxt.port3_output_data     = REG_RESET;
      st_nxt.port4_direction       = REG_RESET;
      st_nxt.port4_output_data     = REG_RESET;
      st_nxt.port4_pullup_control  = REG_RESET;
      st_nxt.area_bus_width_config = REG_RESET;
      st_nxt.ack                   = req;
      st_nxt.rdata                 = UNMAPPED_VAL;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '0;                                              // R3 R5 R9 R13
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_avs_readdata    = st_r.rdata;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !st_r.ack;
  assign o_p2_pullup_en    = st_r.p2_pu;
  assign o_p3_out          = st_r.p3_out;
  assign o_p3_oe           = st_r.p3_oe;
  assign o_p4_out          = st_r.p4_out;
  assign o_p4_oe           = st_r.p4_oe;
  assign o_p4_pullup_en    = st_r.p4_pu;
  assign o_p3_is_bus       = st_r.p3_bus;
  assign o_p4_is_bus       = st_r.p4_bus;
endmodule // mpgm_gpio_top

// File: hw/mpgm_pin_sync.sv
// Two-flop synchroniser for the port-three and port-four pin levels.
// Assumes asynchronous pin inputs and one core clock.
`timescale 1ns/1ps
module mpgm_pin_sync (
  input  wire logic   i_core_clk,
  input  wire logic   i_arst_n,
  mpgm_sync_if.sync   s
);
  import mpgm_pkg::*;
  typedef struct packed {
    logic [7:0] p3_a;
    logic [7:0] p3_b;
    logic [7:0] p4_a;
    logic [7:0] p4_b;
  } mpgm_sync_s;
  mpgm_sync_s st_r;
  mpgm_sync_s st_nxt;
  always_comb begin
    st_nxt      = st_r;
    st_nxt.p3_a = s.p3_raw;   // R20
    st_nxt.p3_b = st_r.p3_a;  // R20
    st_nxt.p4_a = s.p4_raw;
    st_nxt.p4_b = st_r.p4_a;
  end
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign s.p3_sync = st_r.p3_b;
  assign s.p4_sync = st_r.p4_b;
endmodule // mpgm_pin_sync

// File: hw/mpgm_pkg.sv
// Constants for the three-port GPIO mode mux.
// Assumes a 16-bit index space reached as byte address = 4 * index on Avalon-MM.
// Behaviour
// R1: Modes 5-7: port-two pull-up needs input and bit.
// R2: Modes 1-4: port-two pull-ups always off.
// R3: Reset, hardware standby: port-two pull-ups off.
// R4: Port-two pull-up control register, 8 bits.
// R5: Port-two pull-up register cleared, kept in soft standby.
// R6: Modes 1-6: port three is data bus.
// R7: Mode 7: port-three direction bit selects output.
// R8: Port-three direction write-only, reads all ones.
// R9: Port-three direction cleared, kept in soft standby.
// R10: Soft standby: port-three outputs keep driving.
// R11: Port-three output pins driven from output data.
// R12: Port-three read mixes stored data and pins.
// R13: Port-three output data cleared, kept in soft standby.
// R14: All areas 8-bit: port four is GPIO.
// R15: Any 16-bit area: port four joins data bus.
// R16: Mode 7: port four always GPIO.
// R17: Port-four direction bit selects output.
// R18: Port-four direction write-only, reads all ones.
// R19: Port-four pull-up needs GPIO, input and bit.
// R20: Pin levels read through two-stage synchroniser.
package mpgm_pkg;
  localparam logic [15:0] P3_DIR_IDX    = 16'hFFC4;
  localparam logic [15:0] P4_DIR_IDX    = 16'hFFC5;
  localparam logic [15:0] P3_DATA_IDX   = 16'hFFC6;
  localparam logic [15:0] P4_DATA_IDX   = 16'hFFC7;
  localparam logic [15:0] P2_PULL_IDX   = 16'hFFD8;
  localparam logic [15:0] P4_PULL_IDX   = 16'hFFDA;
  localparam logic [15:0] BUS_WIDTH_IDX = 16'hFFEC;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [7:0]  WO_READ_VAL   = 8'hFF;
  localparam logic [31:0] UNMAPPED_VAL  = 32'h00000000;
  localparam logic [2:0]  MODE_SINGLE   = 3'h7;
  localparam logic [2:0]  MODE_ROM_ON   = 3'h5;
  localparam int          SYNC_STAGES   = 2;
endpackage

// File: hw/mpgm_sw_standby_latch.sv
// Holds the standby-frozen copy of port-three and port-four output data while in software standby.
// Assumes standby inputs already synchronous.
`timescale 1ns/1ps
module mpgm_sw_standby_latch #(
  parameter int W = 16
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_arst_n,
  input  wire logic         i_hold,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] q;
  } mpgm_hold_s;
  mpgm_hold_s st_r;
  mpgm_hold_s st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (!i_hold) begin
      st_nxt.q = i_d;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign o_q = st_r.q;
endmodule // mpgm_sw_standby_latch

// File: hw/mpgm_sync_if.sv
// Carrier between the top and its pin synchroniser.
// Assumes both ends on i_core_clk.
`timescale 1ns/1ps
interface mpgm_sync_if;
  logic [7:0] p3_raw;
  logic [7:0] p4_raw;
  logic [7:0] p3_sync;
  logic [7:0] p4_sync;
  modport top  (output p3_raw, output p4_raw, input p3_sync, input p4_sync);
  modport sync (input p3_raw, input p4_raw, output p3_sync, output p4_sync);
endinterface

// File: verification/mpgm_gpio_asserts.sv
// Checker for the three-port GPIO mode mux.
// Assumes binding to mpgm_gpio_top, one clock.
`timescale 1ns/1ps
module mpgm_gpio_asserts
  import mpgm_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_arst_n,
  input wire logic [2:0]  i_mode,
  input wire logic        i_hw_standby,
  input wire logic        i_sw_standby,
  input wire logic [7:0]  i_port2_direction,
  input wire logic [13:0] i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic [7:0]  o_p2_pullup_en,
  input wire logic [7:0]  o_p3_out,
  input wire logic [7:0]  o_p3_oe,
  input wire logic [7:0]  o_p4_pullup_en,
  input wire logic        o_p3_is_bus,
  input wire logic        o_p4_is_bus
);
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  chk_wait_first: assert property ($rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest)
    else $error("waitrequest low on new request");
  chk_wait_one: assert property ((i_avs_read | i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("waitrequest held too long");
  chk_dir_ones: assert property (
    i_avs_read && o_avs_waitrequest && (i_avs_address == P3_DIR_IDX[13:0]
    || i_avs_address == P4_DIR_IDX[13:0]) |=> o_avs_readdata == 32'h000000FF)
    else $error("direction read not all ones");
  chk_p2_low_modes: assert property (
    i_mode inside {[3'h1:3'h4]} |=> o_p2_pullup_en == 8'h00) else $error("p2 pull-up on");
  chk_p2_pull_input: assert property (
    (o_p2_pullup_en & $past(i_port2_direction)) == 8'h00) else $error("p2 pull-up on output");
  chk_hw_pull_off: assert property (
    i_hw_standby |-> ##2 (o_p2_pullup_en == 8'h00 && o_p4_pullup_en == 8'h00))
    else $error("pull-up on in hardware standby");
  chk_p3_bus: assert property (
    (!i_hw_standby && !i_sw_standby && i_mode inside {[3'h1:3'h6]})[*2] |=> o_p3_is_bus)
    else $error("port three not bus");
  chk_single_gpio: assert property (
    (!i_hw_standby && !i_sw_standby && i_mode == 3'h7)[*2] |=> !o_p3_is_bus && !o_p4_is_bus)
    else $error("bus in single-chip mode");
  chk_p4_bus_pull: assert property (o_p4_is_bus |-> o_p4_pullup_en == 8'h00)
    else $error("p4 pull-up on bus");
  chk_sw_hold: assert property (
    i_sw_standby |=> $stable(o_p3_oe) && $stable(o_p3_out & o_p3_oe))
    else $error("p3 drive moved in standby");
endmodule // mpgm_gpio_asserts

bind mpgm_gpio_top mpgm_gpio_asserts u_chk (.i_core_clk, .i_arst_n, .i_mode,
  .i_hw_standby, .i_sw_standby, .i_port2_direction, .i_avs_address, .i_avs_read,
  .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .o_p2_pullup_en, .o_p3_out,
  .o_p3_oe, .o_p4_pullup_en, .o_p3_is_bus, .o_p4_is_bus);

// File: verification/mpgm_pin_model.sv
// Outside world of one 8-bit port.
// Assumes out and oe from the block; pins driven by neither the block nor i_ext (i_ext_en low) float unless pulled up.
`timescale 1ns/1ps
module mpgm_pin_model (
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_pull,
  input  wire logic [7:0] i_ext,
  input  wire logic [7:0] i_ext_en,
  output logic      [7:0] o_pin
);
  // ----------------
  // Pin resolution
  // ----------------
  logic [7:0] float_r = 8'h5A;
  always @(posedge i_core_clk) float_r <= ~float_r;
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext)
               | (~i_oe & ~i_ext_en & (i_pull | float_r));
endmodule // mpgm_pin_model

// File: verification/multi_port_gpio_mode_mux_bench.sv
// Self-checking bench for the three-port GPIO mode mux.
// Assumes the checker binds itself to the top.
`timescale 1ns/1ps
module multi_port_gpio_mode_mux_bench;
  import mpgm_pkg::*;
  logic        i_core_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic [2:0]  i_mode = 3'h7;
  logic        i_hw_standby = 1'b0;
  logic        i_sw_standby = 1'b0;
  logic [7:0]  i_port2_direction = 8'h00;
  logic [13:0] i_avs_address = 14'h0000;
  logic        i_avs_read = 1'b0;
  logic        i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h00000000;
  logic [3:0]  i_avs_byteenable = 4'hF;
  logic [7:0]  i_p3_pin, i_p4_pin, o_p2_pullup_en, o_p3_out, o_p3_oe;
  logic [7:0]  o_p4_out, o_p4_oe, o_p4_pullup_en;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest, o_p3_is_bus, o_p4_is_bus;
  logic [7:0]  ext = 8'hA5;
  int          err_count = 0;
  int          n_compared = 0;
  // ----------------
  // Harness
  // ----------------
  always #10 i_core_clk = ~i_core_clk;
  mpgm_gpio_top dut (.i_core_clk, .i_arst_n, .i_mode, .i_hw_standby, .i_sw_standby,
    .i_port2_direction, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .i_p3_pin, .i_p4_pin, .o_avs_readdata, .o_avs_waitrequest,
    .o_p2_pullup_en, .o_p3_out, .o_p3_oe, .o_p4_out, .o_p4_oe, .o_p4_pullup_en,
    .o_p3_is_bus, .o_p4_is_bus);
  mpgm_pin_model p3m (.i_core_clk, .i_out(o_p3_out), .i_oe(o_p3_oe), .i_pull(8'h00),
    .i_ext(ext), .i_ext_en(8'hFF), .o_pin(i_p3_pin));
  mpgm_pin_model p4m (.i_core_clk, .i_out(o_p4_out), .i_oe(o_p4_oe),
    .i_pull(o_p4_pullup_en), .i_ext(ext), .i_ext_en(8'h0F), .o_pin(i_p4_pin));
  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d,
                     output logic [31:0] q);
    int i;
    @(posedge i_core_clk);
    i_avs_address <= idx[13:0];
    i_avs_writedata <= {24'h000000, d};
    i_avs_read <= !w;
    i_avs_write <= w;
    for (i = 0; i < 20; i++) begin
      @(posedge i_core_clk);
      if (o_avs_waitrequest === 1'b0) break;
    end
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    if (i == 20) begin
      err_count++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(q, exp);
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset();
    rd(P3_DIR_IDX, 32'h000000FF);
    rd(P4_DIR_IDX, 32'h000000FF);
    rd(P2_PULL_IDX, 32'h00000000);
    rd(P3_DATA_IDX, 32'h000000A5);
    check(32'(o_p3_out), 32'h00000000);
    rd(16'hFFC0, UNMAPPED_VAL);
    $display("Test reset done");
  endtask
  task automatic t_p3_gpio();
    wr(P3_DIR_IDX, 8'h0F);
    wr(P3_DATA_IDX, 8'h3C);
    i_avs_byteenable <= 4'h0;
    wr(P3_DATA_IDX, 8'hFF);
    i_avs_byteenable <= 4'hF;
    tick(2);
    check(32'(o_p3_oe), 32'h0000000F);
    check(32'(o_p3_out & o_p3_oe), 32'h0000000C);
    rd(P3_DATA_IDX, 32'h000000AC);
    $display("Test port three done");
  endtask
  task automatic t_p2_pull();
    wr(P2_PULL_IDX, 8'hFF);
    i_port2_direction <= 8'h0F;
    for (int m = 1; m < 8; m++) begin
      i_mode <= m[2:0];
      tick(3);
      check(32'(o_p2_pullup_en), (m >= 5) ? 32'h000000F0 : 32'h00000000);
    end
    rd(P2_PULL_IDX, 32'h000000FF);
    $display("Test port two done");
  endtask
  task automatic t_p4_modes();
    i_mode <= 3'h3;
    wr(BUS_WIDTH_IDX, 8'h00);
    wr(P4_DIR_IDX, 8'h33);
    wr(P4_PULL_IDX, 8'hFF);
    tick(2);
    check(32'({o_p3_is_bus, o_p4_is_bus}), 32'h00000002);
    check(32'({o_p4_oe, o_p4_pullup_en}), 32'h000033CC);
    wr(BUS_WIDTH_IDX, 8'h01);
    tick(2);
    check(32'({o_p4_is_bus, o_p4_pullup_en}), 32'h00000100);
    i_mode <= 3'h7;
    tick(3);
    check(32'({o_p3_is_bus, o_p4_is_bus, o_p4_pullup_en}), 32'h000000CC);
    wr(P4_DATA_IDX, 8'h96);
    tick(3);
    check(32'(o_p4_out & o_p4_oe), 32'h00000012);
    rd(P4_DATA_IDX, 32'h000000D6);
    rd(P4_PULL_IDX, 32'h000000FF);
    rd(BUS_WIDTH_IDX, 32'h00000001);
    $display("Test port four done");
  endtask
  task automatic t_standby();
    wr(P3_DATA_IDX, 8'h35);
    i_sw_standby <= 1'b1;
    ext <= 8'h5A;
    tick(4);
    check(32'(o_p3_out & o_p3_oe), 32'h00000005);
    check(32'(o_p2_pullup_en), 32'h000000F0);
    wr(P3_DATA_IDX, 8'h3C);
    tick(2);
    check(32'(o_p3_out & o_p3_oe), 32'h00000005);
    i_sw_standby <= 1'b0;
    rd(P2_PULL_IDX, 32'h000000FF);
    rd(P3_DATA_IDX, 32'h0000005C);
    i_hw_standby <= 1'b1;
    tick(3);
    check(32'({o_p2_pullup_en, o_p4_pullup_en}), 32'h00000000);
    check(32'(o_p3_oe), 32'h00000000);
    check(32'(o_p3_out), 32'h00000000);
    i_hw_standby <= 1'b0;
    rd(P2_PULL_IDX, 32'h00000000);
    rd(P3_DATA_IDX, 32'h0000005A);
    $display("Test standby done");
  endtask
  initial begin
    tick(16);
    i_arst_n <= 1'b1;
    t_reset();
    t_p3_gpio();
    t_p2_pull();
    t_p4_modes();
    t_standby();
    finish_test();
  end
endmodule // multi_port_gpio_mode_mux_bench
